// File: safety_response_pkg.sv
/*
 Shared constants and types for the safety response configuration block.
 Assumes a 20 MHz system clock and a command decoder that presents register
 read and write commands as one-cycle strobes.
*/
`default_nettype none
package safety_response_pkg;
   // ****************************************
   // Register layout
   // ****************************************
   localparam int REG_W          = 8;
   localparam int TH_LSB         = 0;
   localparam int TH_W           = 4;
   localparam int TO_LSB         = 4;
   localparam int TO_W           = 2;
   localparam int B_CLKWARN      = 7;
   localparam int B_SCHED        = 5;
   localparam int B_AUTODIS      = 4;
   localparam int B_BISTFAIL     = 3;
   localparam int B_DRVERR       = 2;
   localparam int B_RSTERR_RST   = 1;
   localparam int B_RSTERR_SAFE  = 0;
   localparam logic [7:0] RESP_WMASK  = 8'hBF;
   localparam logic [7:0] CFG1_RESET  = 8'h00;
   localparam logic [7:0] CFG2_RESET  = 8'h00;
   localparam logic [1:0] TO_640      = 2'h0;
   localparam logic [1:0] TO_320      = 2'h1;
   localparam logic [1:0] TO_5        = 2'h2;
   localparam logic [1:0] TO_1P25     = 2'h3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ         = 20000000;
   localparam int T640_US        = 640000;
   localparam int T320_US        = 320000;
   localparam int T5_US          = 5000;
   localparam int T1P25_US       = 1250;
   localparam int CYC_PER_US     = CLK_HZ / 1000000;
   localparam int CYC640         = T640_US * CYC_PER_US;
   localparam int CYC320         = T320_US * CYC_PER_US;
   localparam int CYC5           = T5_US * CYC_PER_US;
   localparam int CYC1P25        = T1P25_US * CYC_PER_US;
   localparam int TMR_W          = 24;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ST_DIAG   = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_SAFE   = 2'b10,
      ST_RESET  = 2'b11
   } dev_state_e;

   typedef struct packed {
      logic clockWarning;
      logic selftestFail;
      logic drivePinError;
      logic resetPinError;
   } fault_s;
endpackage
`default_nettype wire

// File: safety_response_config.sv
/*
 Safe-state config and safety response config registers with the SAFE,
 RESET and self-test decisions they steer: fault responses, the SAFE
 time-out timer with its lock threshold, and the self-test enables.
 Assumes fault inputs, error count and device state come from logic on
 the same clock, so none of them is synchronised here.
 Assumes the command decoder outside presents each register write as a
 one-cycle strobe with its data, and that the state machine outside
 applies the requested moves; the safe-state config has no write path
 here and keeps its reset value.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Two-bit field selects SAFE time-out
// - Lock threshold bits 3-0, select bits 5-4
// - Timeout-disable clear: leave SAFE on expiry
// - Count within threshold: leave SAFE on expiry
// - Timeout-disable set, count over threshold: stay locked in SAFE
// - Writes only in DIAGNOSTIC, lock clear
// - Safety response config contents feed configuration checksum
// - Clock warning response enable to SAFE
// - Scheduler runs in ACTIVE with group start
// - Auto self-test on RESET unless disabled
// - Self-test failure response enable to SAFE
// - Drive pin error response to SAFE
// - Reset pin error to RESET
// - Reset pin error to SAFE
// - RESET response wins over SAFE response
module safety_response_config
   import safety_response_pkg::*;
#(
   parameter int CYCLES_640  = CYC640,
   parameter int CYCLES_320  = CYC320,
   parameter int CYCLES_5    = CYC5,
   parameter int CYCLES_1P25 = CYC1P25
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  wire logic               clkEnable,
   // Register commands
   input  wire logic               writeResponseConfig,
   input  wire logic [REG_W-1:0]   writeData,
   output logic      [REG_W-1:0]   safeStateConfig,
   output logic      [REG_W-1:0]   safetyResponseConfig,
   // Device status
   input  wire dev_state_e         deviceState,
   input  wire logic               configLock,
   input  wire logic               safeTimeoutDisable,
   input  wire logic [TH_W-1:0]    deviceErrorCount,
   input  wire logic [3:0]         selftestGroupStart,
   input  wire fault_s             faults,
   // Decisions
   output logic                    requestSafe,
   output logic                    requestReset,
   output logic                    selftestSchedulerRun,
   output logic                    autoSelftestRun,
   output logic                    safeTimerExpired,
   output logic [REG_W-1:0]        configChecksumTerm
);
   // ****************************************
   // State decode
   // ****************************************
   wire               inDiag;
   wire               inActive;
   wire               inSafe;
   wire               inReset;

   assign inDiag   = deviceState == ST_DIAG;
   assign inActive = deviceState == ST_ACTIVE;
   assign inSafe   = deviceState == ST_SAFE;
   assign inReset  = deviceState == ST_RESET;

   // ****************************************
   // State groups
   // ****************************************
   wire               diagOrActive;
   wire               notInReset;

   assign diagOrActive = inDiag || inActive;
   assign notInReset   = !inReset;

   // ****************************************
   // Previous state for entry detection
   // ****************************************
   dev_state_e        prevState;
   wire               safeEntry;
   wire               resetEntry;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prevState <= ST_RESET;
      end else if (clkEnable) begin
         prevState <= deviceState;
      end
   end

   assign safeEntry  = inSafe && (prevState != ST_SAFE);
   assign resetEntry = inReset && (prevState != ST_RESET);

   // ****************************************
   // Write qualification
   // ****************************************
   wire  [REG_W-1:0]  next_cfg2;
   wire               writeAllowed;
   wire               writeTaken;

   assign writeAllowed = inDiag && !configLock;
   assign writeTaken   = clkEnable
                         && writeResponseConfig
                         && writeAllowed;
   assign next_cfg2    = writeData & RESP_WMASK;

   // ****************************************
   // Register storage
   // ****************************************
   logic [REG_W-1:0]  cfg1;
   logic [REG_W-1:0]  cfg2;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg1 <= CFG1_RESET;
         cfg2 <= CFG2_RESET;
      end else if (writeTaken) begin
         cfg2 <= next_cfg2;
      end
   end

   // ****************************************
   // Safe-state config fields
   // ****************************************
   wire [TO_W-1:0]    timeoutSel;
   wire [TH_W-1:0]    lockTh;

   assign timeoutSel = cfg1[TO_LSB +: TO_W];
   assign lockTh     = cfg1[TH_LSB +: TH_W];

   // ****************************************
   // Safety response config fields
   // ****************************************
   wire               clockWarnEnable;
   wire               schedulerEnable;
   wire               autoSelftestDisable;
   wire               selftestFailEnable;
   wire               drivePinEnable;
   wire               resetPinToResetEnable;
   wire               resetPinToSafeEnable;

   assign clockWarnEnable       = cfg2[B_CLKWARN];
   assign schedulerEnable       = cfg2[B_SCHED];
   assign autoSelftestDisable   = cfg2[B_AUTODIS];
   assign selftestFailEnable    = cfg2[B_BISTFAIL];
   assign drivePinEnable        = cfg2[B_DRVERR];
   assign resetPinToResetEnable = cfg2[B_RSTERR_RST];
   assign resetPinToSafeEnable  = cfg2[B_RSTERR_SAFE];

   // ****************************************
   // Register outputs
   // ****************************************
   assign safeStateConfig      = cfg1;
   assign safetyResponseConfig = cfg2;
   assign configChecksumTerm   = cfg2;

   // ****************************************
   // SAFE time-out load value
   // ****************************************
   logic [TMR_W-1:0]  timeoutLoad;

   always_comb begin
      unique case (timeoutSel)
         TO_640:  timeoutLoad = TMR_W'(CYCLES_640 - 1);
         TO_320:  timeoutLoad = TMR_W'(CYCLES_320 - 1);
         TO_5:    timeoutLoad = TMR_W'(CYCLES_5 - 1);
         TO_1P25: timeoutLoad = TMR_W'(CYCLES_1P25 - 1);
      endcase
   end

   // ****************************************
   // SAFE time-out timer
   // ****************************************
   logic [TMR_W-1:0]  safeTimer;
   logic [TMR_W-1:0]  next_safeTimer;
   wire               timerAtZero;

   assign timerAtZero = safeTimer == '0;

   always_comb begin
      if (!inSafe || safeEntry) begin
         next_safeTimer = timeoutLoad;
      end else if (!timerAtZero) begin
         next_safeTimer = safeTimer - TMR_W'(1);
      end else begin
         next_safeTimer = safeTimer;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         safeTimer <= '0;
      end else if (clkEnable) begin
         safeTimer <= next_safeTimer;
      end
   end

   // ****************************************
   // SAFE time-out expiry
   // ****************************************
   logic              timerDone;
   wire               next_timerDone;

   assign next_timerDone = inSafe
                           && !safeEntry
                           && timerAtZero;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timerDone <= 1'b0;
      end else if (clkEnable) begin
         timerDone <= next_timerDone;
      end
   end

   // Expiry only counts while still in SAFE
   assign safeTimerExpired = timerDone && inSafe;

   // ****************************************
   // SAFE lock threshold
   // ****************************************
   wire               countOverThreshold;
   wire               lockedSafe;
   wire               safeExit;

   assign countOverThreshold = deviceErrorCount > lockTh;
   assign lockedSafe         = safeTimeoutDisable && countOverThreshold;
   assign safeExit           = timerDone
                               && inSafe
                               && !lockedSafe;

   // ****************************************
   // Per-source SAFE responses
   // ****************************************
   localparam int     N_SRC = $bits(fault_s);
   wire [N_SRC-1:0]   srcFault;
   wire [N_SRC-1:0]   srcEnable;
   wire [N_SRC-1:0]   srcHit;

   assign srcFault  = {faults.clockWarning,
                       faults.selftestFail,
                       faults.drivePinError,
                       faults.resetPinError};
   assign srcEnable = {clockWarnEnable,
                       selftestFailEnable,
                       drivePinEnable,
                       resetPinToSafeEnable};

   generate
      for (genvar i = 0; i < N_SRC; i++) begin : g_src
         assign srcHit[i] = srcFault[i] && srcEnable[i];
      end
   endgenerate

   // ****************************************
   // RESET requests
   // ****************************************
   wire               resetPinToReset;

   assign resetPinToReset = faults.resetPinError
                            && resetPinToResetEnable
                            && notInReset;
   assign requestReset    = resetPinToReset
                            || safeExit;

   // ****************************************
   // SAFE requests
   // ****************************************
   wire               anySafeHit;
   wire               safeAllowed;

   assign anySafeHit  = |srcHit;
   assign safeAllowed = diagOrActive
                        && !resetPinToReset;
   assign requestSafe = safeAllowed && anySafeHit;

   // ****************************************
   // Self-test scheduler
   // ****************************************
   wire               anyGroupStart;

   assign anyGroupStart        = |selftestGroupStart;
   assign selftestSchedulerRun = inActive
                                 && schedulerEnable
                                 && anyGroupStart;

   // ****************************************
   // Automatic self-test
   // ****************************************
   assign autoSelftestRun = resetEntry
                            && !autoSelftestDisable;
endmodule // safety_response_config
`default_nettype wire

// File: safety_response_chk.sv
/* Assertions on the safety response config block ports.
 Assumes it is bound into the block, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module safety_response_chk
   import safety_response_pkg::*;
(
   input wire logic       clk_sys, reset, clkEnable, writeResponseConfig, configLock, safeTimeoutDisable,
   input wire logic       requestSafe, requestReset, selftestSchedulerRun, autoSelftestRun, safeTimerExpired,
   input wire logic [7:0] writeData, safeStateConfig, safetyResponseConfig, configChecksumTerm,
   input wire logic [3:0] deviceErrorCount, selftestGroupStart,
   input wire dev_state_e deviceState,
   input wire fault_s     faults
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire [7:0] cfg = safetyResponseConfig;
   wire take = clkEnable && writeResponseConfig && deviceState == ST_DIAG && !configLock;
   wire pinRst = faults.resetPinError && cfg[1] && deviceState != ST_RESET;
   wire over = deviceErrorCount > safeStateConfig[3:0];
   write_taken_a: assert property (take |=> cfg == ($past(writeData) & RESP_WMASK))
      else $error("write lost");
   write_dropped_a: assert property (!take |=> $stable(cfg))
      else $error("write not dropped");
   checksum_feed_a: assert property (configChecksumTerm == cfg)
      else $error("checksum term differs");
   reset_wins_a: assert property (pinRst |-> requestReset && !requestSafe)
      else $error("reset response lost");
   sched_run_a: assert property (selftestSchedulerRun == (deviceState == ST_ACTIVE && cfg[5] && |selftestGroupStart))
      else $error("scheduler run wrong");
   auto_bist_a: assert property (autoSelftestRun |-> deviceState == ST_RESET && !cfg[4])
      else $error("auto self-test wrong");
   timeout_reset_a: assert property (safeTimerExpired && !safeTimeoutDisable |-> requestReset)
      else $error("time-out reset lost");
   lock_hold_a: assert property (safeTimerExpired && safeTimeoutDisable && over && !pinRst |-> !requestReset)
      else $error("lock not held");
endmodule // safety_response_chk
bind safety_response_config safety_response_chk i_chk (.*);
`default_nettype wire

// File: mcu_cmd_model.sv
/* MCU side issuing one-cycle register write commands.
 Assumes commands are taken on the rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module mcu_cmd_model (
   input  wire logic       clk_sys,
   output logic            writeResponseConfig,
   output logic [7:0]      writeData
);
   initial begin
      writeResponseConfig = 1'b0;
      writeData = 8'h00;
   end
   task automatic send(input logic [7:0] d);
      @(negedge clk_sys);
      writeResponseConfig = 1'b1;
      writeData = d;
      @(negedge clk_sys);
      writeResponseConfig = 1'b0;
      writeData = ~d;
   endtask
endmodule // mcu_cmd_model
`default_nettype wire

// File: test_safety_response_config.sv
/* Bench for the safety response config block.
 Assumes the MCU model and shortened time-out counts. */
`timescale 1ns/10ps
`default_nettype none
module test_safety_response_config
   import safety_response_pkg::*;
;
   logic       clk_sys = 1'b0, reset, clkEnable, configLock, safeTimeoutDisable;
   logic       writeResponseConfig, requestSafe, requestReset, selftestSchedulerRun, autoSelftestRun, safeTimerExpired;
   logic [7:0] writeData, safeStateConfig, safetyResponseConfig, configChecksumTerm, cfgv;
   logic [3:0] deviceErrorCount, selftestGroupStart;
   dev_state_e deviceState;
   fault_s     faults;
   int         error_cnt = 0, checked = 0, n;
   always #25 clk_sys = ~clk_sys;
   mcu_cmd_model i_mcu (.*);
   safety_response_config #(.CYCLES_640(20), .CYCLES_320(10), .CYCLES_5(5), .CYCLES_1P25(3)) i_dut (.*);
   task automatic chk(input string what, input logic [7:0] exp, got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [1:0] resp(input logic [7:0] c, input fault_s f, input dev_state_e s);
      logic rr;
      rr = f.resetPinError & c[1] & (s != ST_RESET);
      return {rr, ~rr & (s <= ST_ACTIVE) & |({f.clockWarning, f.selftestFail, f.drivePinError, f.resetPinError} & {c[7], c[3:2], c[0]})};
   endfunction
   task automatic safe_run(output int k);
      deviceState = ST_SAFE;
      k = 0;
      while (safeTimerExpired !== 1'b1 && k < 40) begin
         @(negedge clk_sys);
         k++;
      end
   endtask
   initial begin
      reset = 1'b1;
      clkEnable = 1'b1;
      configLock = 1'b0;
      safeTimeoutDisable = 1'b0;
      deviceErrorCount = 4'h0;
      selftestGroupStart = 4'h0;
      deviceState = ST_DIAG;
      faults = 4'h0;
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      chk("cfg1", 8'h00, safeStateConfig);
      chk("cfg2", 8'h00, safetyResponseConfig);
      i_mcu.send(8'hFF);
      chk("write", 8'hBF, safetyResponseConfig);
      chk("checksum", 8'hBF, configChecksumTerm);
      clkEnable = 1'b0;
      i_mcu.send(8'h0D);
      chk("frozen", 8'hBF, safetyResponseConfig);
      clkEnable = 1'b1;
      configLock = 1'b1;
      i_mcu.send(8'h0D);
      chk("locked", 8'hBF, safetyResponseConfig);
      configLock = 1'b0;
      deviceState = ST_ACTIVE;
      i_mcu.send(8'h0D);
      chk("active", 8'hBF, safetyResponseConfig);
      $display("test register write done");
      for (int c = 0; c < 2; c++) begin
         deviceState = ST_DIAG;
         if (c == 1) i_mcu.send(8'h0D);
         cfgv = c ? 8'h0D : 8'hBF;
         for (n = 0; n < 32; n++) begin
            deviceState = n[4] ? ST_ACTIVE : ST_DIAG;
            faults = n[3:0];
            selftestGroupStart = n[3:0];
            @(negedge clk_sys);
            chk("resp", {6'h00, resp(cfgv, faults, deviceState)}, {6'h00, requestReset, requestSafe});
            chk("sched", {7'h00, n[4] & cfgv[5] & |n[3:0]}, {7'h00, selftestSchedulerRun});
         end
         faults = 4'h0;
         deviceState = ST_RESET;
         #1;
         chk("auto", {7'h00, ~cfgv[4]}, {7'h00, autoSelftestRun});
         @(negedge clk_sys);
         $display("test fault table %0d done", c);
      end
      safe_run(n);
      chk("timeout", 8'h15, n[7:0]);
      chk("expiry", 8'h01, {7'h00, requestReset});
      safeTimeoutDisable = 1'b1;
      deviceErrorCount = 4'h1;
      #1;
      chk("locked", 8'h00, {7'h00, requestReset});
      @(negedge clk_sys);
      deviceErrorCount = 4'h0;
      #1;
      chk("unlocked", 8'h01, {7'h00, requestReset});
      @(negedge clk_sys);
      deviceState = ST_ACTIVE;
      @(negedge clk_sys);
      safe_run(n);
      chk("restart", 8'h15, n[7:0]);
      $display("test time-out done");
      give_verdict;
   end
   initial begin
      #200000;
      error_cnt++;
      give_verdict;
   end
endmodule // test_safety_response_config
`default_nettype wire
